//--- rtl/homing_pkg.sv
// Purpose: Shared constants and types for the switch-and-index homing sequencer
// Assumes: Method codes 8 to 13, one control clock, active-high switch levels
// Notes:   Segment code is {direction positive, high speed, ends on falling edge}
//
// Contract
// [R1] Codes 8-10 reverse at positive limit, 11-13 at negative; all end on index.
// [R2] M8 clear: +fast; rise: -slow; fall: +slow; index after next rise.
// [R3] M8 on switch: -slow; fall: +slow; index after first rise.
// [R4] M8 limit: -fast; rise: slow; fall: +slow; index after next rise.
// [R5] M9 clear: +fast; rise: +slow; fall: -slow; index after rise.
// [R6] M9 on switch: +slow; fall: -slow; index after first rise.
// [R7] M9 limit: -fast; rise: +slow; fall: -slow; index after rise.
// [R8] M10 clear: +fast; rise: +slow; index after fall.
// [R9] M10 on switch: +slow; index after fall.
// [R10] M10 limit: -fast; rise: +slow; index after fall.
// [R11] M11 clear: -fast; rise: +slow; index after fall.
// [R12] M11 on switch: +slow; index after fall.
// [R13] M12 clear: -fast; rise: +slow; fall: -slow; index after next rise.
// [R14] M12 on switch: +slow; fall: -slow; index after rise.
// [R15] M12 limit: +fast; rise: slow; fall: -slow; index after next rise.
// [R16] M13 clear: -fast; rise: slow; fall: +slow; index after next rise.
// [R17] M13 on switch: -slow; fall: +slow; index after rise.
// [R18] M13 limit: +fast; rise: -slow; index after fall.
// [R19] Switch level sampled once at start; edges from registered successive samples.
// [R20] M11 limit: +fast; rise: slow; index after fall.

package homing_pkg;

  // Method codes served
  localparam logic [7:0] METHOD_FIRST     = 8'h08;
  localparam logic [7:0] METHOD_POS_LAST  = 8'h0a;
  localparam logic [7:0] METHOD_LAST      = 8'h0d;

  // Starting case: clear or on switch picked at start, limit on a reversal
  localparam logic [1:0] CASE_CLEAR       = 2'h0;
  localparam logic [1:0] CASE_ON_SWITCH   = 2'h1;
  localparam logic [1:0] CASE_LIMIT       = 2'h2;

  // Segment field positions and width
  localparam int         SEG_W            = 3;
  localparam int         SEG_DIR_BIT      = 2;
  localparam int         SEG_FAST_BIT     = 1;
  localparam int         SEG_FALL_BIT     = 0;
  localparam int         PLAN_W           = 11;
  localparam int         PLAN_CNT_LSB     = 9;

  // Segment codes: direction, speed, ending edge
  localparam logic [2:0] SEG_NONE         = 3'h0;
  localparam logic [2:0] SEG_NEG_SLOW_R   = 3'h0;
  localparam logic [2:0] SEG_NEG_SLOW_F   = 3'h1;
  localparam logic [2:0] SEG_NEG_FAST_R   = 3'h2;
  localparam logic [2:0] SEG_POS_SLOW_R   = 3'h4;
  localparam logic [2:0] SEG_POS_SLOW_F   = 3'h5;
  localparam logic [2:0] SEG_POS_FAST_R   = 3'h6;

  // Segment counts
  localparam logic [1:0] SEGS_1           = 2'h1;
  localparam logic [1:0] SEGS_2           = 2'h2;
  localparam logic [1:0] SEGS_3           = 2'h3;

  // Input pin slots and pin count
  localparam int         PIN_COUNT        = 4;
  localparam int         PIN_HOME         = 0;
  localparam int         PIN_POS_LIMIT    = 1;
  localparam int         PIN_NEG_LIMIT    = 2;
  localparam int         PIN_INDEX        = 3;

  // Reset values
  localparam logic [1:0] SEG_IDX_RESET    = 2'h0;
  localparam logic [7:0] METHOD_RESET     = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_MOVE  = 5'b00010,
    ST_SEEK  = 5'b00100,
    ST_DONE  = 5'b01000,
    ST_FAULT = 5'b10000
  } homing_state_t;

endpackage : homing_pkg

//--- rtl/homing_switch_index_sequencer.sv
// Purpose: Drives direction and speed commands through homing methods 8 to 13
// Assumes: Switch, limit and index pins are asynchronous, active high
// Notes:   Deceleration ramps belong to the trajectory generator downstream

`timescale 1ns/1ps

module homing_switch_index_sequencer (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] method_code,
  input  wire logic       start,
  input  wire logic       halt,
  input  wire logic       home_switch,
  input  wire logic       pos_limit,
  input  wire logic       neg_limit,
  input  wire logic       index_pulse,
  output logic            move_en,
  output logic            dir_positive,
  output logic            speed_high,
  output logic            busy,
  output logic            home_found,
  output logic            fault
);

  // ****************************************************************
  // Input synchronisers and edge detection
  // ****************************************************************

  logic [homing_pkg::PIN_COUNT-1:0] pin_raw;
  logic [homing_pkg::PIN_COUNT-1:0] sync1_reg;
  logic [homing_pkg::PIN_COUNT-1:0] sync2_reg;
  logic [homing_pkg::PIN_COUNT-1:0] prev_reg;
  logic [homing_pkg::PIN_COUNT-1:0] pin_rise;
  logic [homing_pkg::PIN_COUNT-1:0] pin_fall;

  assign pin_raw[homing_pkg::PIN_HOME]      = home_switch;
  assign pin_raw[homing_pkg::PIN_POS_LIMIT] = pos_limit;
  assign pin_raw[homing_pkg::PIN_NEG_LIMIT] = neg_limit;
  assign pin_raw[homing_pkg::PIN_INDEX]     = index_pulse;

  genvar gi;
  generate
    for (gi = 0; gi < homing_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
      // Edges only from the settled stages, never the first flop
      assign pin_rise[gi] = sync2_reg[gi] & ~prev_reg[gi];  // [R19]
      assign pin_fall[gi] = ~sync2_reg[gi] & prev_reg[gi];  // [R19]
    end
  endgenerate

  // ****************************************************************
  // Motion plans
  // ****************************************************************

  // Returns {segment count, seg2, seg1, seg0}; seg0 runs first
  function automatic logic [homing_pkg::PLAN_W-1:0] plan_lookup(
    input logic [7:0] code,
    input logic [1:0] start_case
  );
    logic [homing_pkg::PLAN_W-1:0] p;
    p = '0;
    unique case (code)
      8'h08: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_3, homing_pkg::SEG_POS_SLOW_R,
                                           homing_pkg::SEG_NEG_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R2]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_R,
                                           homing_pkg::SEG_NEG_SLOW_F};  // [R3]
          default:                    p = {homing_pkg::SEGS_3, homing_pkg::SEG_POS_SLOW_R,
                                           homing_pkg::SEG_NEG_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R4]
        endcase
      end
      8'h09: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_3, homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R5]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F};  // [R6]
          default:                    p = {homing_pkg::SEGS_3, homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R7]
        endcase
      end
      8'h0a: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R8]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_1, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F};  // [R9]
          default:                    p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R10]
        endcase
      end
      8'h0b: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R11]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_1, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F};  // [R12]
          default:                    p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R20]
        endcase
      end
      8'h0c: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_3, homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R13]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F};  // [R14]
          default:                    p = {homing_pkg::SEGS_3, homing_pkg::SEG_NEG_SLOW_R,
                                           homing_pkg::SEG_POS_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R15]
        endcase
      end
      default: begin
        unique case (start_case)
          homing_pkg::CASE_CLEAR:     p = {homing_pkg::SEGS_3, homing_pkg::SEG_POS_SLOW_R,
                                           homing_pkg::SEG_NEG_SLOW_F,
                                           homing_pkg::SEG_NEG_FAST_R};  // [R16]
          homing_pkg::CASE_ON_SWITCH: p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_POS_SLOW_R,
                                           homing_pkg::SEG_NEG_SLOW_F};  // [R17]
          default:                    p = {homing_pkg::SEGS_2, homing_pkg::SEG_NONE,
                                           homing_pkg::SEG_NEG_SLOW_F,
                                           homing_pkg::SEG_POS_FAST_R};  // [R18]
        endcase
      end
    endcase
    return p;
  endfunction : plan_lookup

  function automatic logic [homing_pkg::SEG_W-1:0] seg_pick(
    input logic [homing_pkg::PLAN_W-1:0] p,
    input logic [1:0]                    idx
  );
    logic [homing_pkg::SEG_W-1:0] s;
    s = p[homing_pkg::SEG_W-1:0];
    if (idx == 2'h1) begin
      s = p[2*homing_pkg::SEG_W-1:homing_pkg::SEG_W];
    end else if (idx == 2'h2) begin
      s = p[3*homing_pkg::SEG_W-1:2*homing_pkg::SEG_W];
    end
    return s;
  endfunction : seg_pick

  // ****************************************************************
  // Sequencing
  // ****************************************************************

  homing_pkg::homing_state_t         state_reg;
  homing_pkg::homing_state_t         state_next;
  logic [7:0]                        method_reg;
  logic [1:0]                        case_reg;
  logic [1:0]                        case_next;
  logic [homing_pkg::PLAN_W-1:0]     plan_reg;
  logic [homing_pkg::PLAN_W-1:0]     plan_next;
  logic [1:0]                        seg_idx_reg;
  logic [1:0]                        seg_idx_next;
  logic [homing_pkg::SEG_W-1:0]      seg_now;
  logic [homing_pkg::SEG_W-1:0]      seg_load;
  logic [1:0]                        plan_count;
  logic                              method_ok;
  logic                              home_level;
  logic                              ref_limit_rise;
  logic                              seg_edge_hit;
  logic                              load_seg;

  assign method_ok  = (method_code >= homing_pkg::METHOD_FIRST) &&
                      (method_code <= homing_pkg::METHOD_LAST);
  assign home_level = sync2_reg[homing_pkg::PIN_HOME];
  assign seg_now    = seg_pick(plan_reg, seg_idx_reg);
  assign plan_count = plan_reg[homing_pkg::PLAN_W-1:homing_pkg::PLAN_CNT_LSB];

  // Reversal point follows the method group
  assign ref_limit_rise = (method_reg <= homing_pkg::METHOD_POS_LAST) ?
                          pin_rise[homing_pkg::PIN_POS_LIMIT] :
                          pin_rise[homing_pkg::PIN_NEG_LIMIT];  // [R1]

  assign seg_edge_hit = seg_now[homing_pkg::SEG_FALL_BIT] ?
                        pin_fall[homing_pkg::PIN_HOME] :
                        pin_rise[homing_pkg::PIN_HOME];

  always_comb begin
    state_next   = state_reg;
    case_next    = case_reg;
    plan_next    = plan_reg;
    seg_idx_next = seg_idx_reg;
    load_seg     = 1'b0;
    if (halt) begin
      state_next = homing_pkg::ST_IDLE;
    end else if (start && (state_reg != homing_pkg::ST_MOVE) &&
                 (state_reg != homing_pkg::ST_SEEK)) begin
      if (method_ok) begin
        // Switch level read once here picks the clear or on-switch plan
        case_next    = home_level ? homing_pkg::CASE_ON_SWITCH :
                                    homing_pkg::CASE_CLEAR;  // [R19]
        plan_next    = plan_lookup(method_code, case_next);
        seg_idx_next = homing_pkg::SEG_IDX_RESET;
        load_seg     = 1'b1;
        state_next   = homing_pkg::ST_MOVE;
      end else begin
        state_next = homing_pkg::ST_FAULT;
      end
    end else begin
      unique case (state_reg)
        homing_pkg::ST_MOVE: begin
          if (ref_limit_rise) begin
            // Limit only legal during the opening fast run of a clear start
            if (case_reg == homing_pkg::CASE_CLEAR &&
                seg_idx_reg == homing_pkg::SEG_IDX_RESET) begin
              case_next    = homing_pkg::CASE_LIMIT;
              plan_next    = plan_lookup(method_reg, homing_pkg::CASE_LIMIT);  // [R1]
              seg_idx_next = homing_pkg::SEG_IDX_RESET;
              load_seg     = 1'b1;
            end else begin
              state_next = homing_pkg::ST_FAULT;
            end
          end else if (seg_edge_hit) begin
            if (seg_idx_reg == plan_count - 2'h1) begin
              // Qualifying edge seen: keep moving, wait for index
              state_next = homing_pkg::ST_SEEK;  // [R1]
            end else begin
              seg_idx_next = seg_idx_reg + 2'h1;
              load_seg     = 1'b1;
            end
          end
        end
        homing_pkg::ST_SEEK: begin
          if (ref_limit_rise) begin
            state_next = homing_pkg::ST_FAULT;
          end else if (pin_rise[homing_pkg::PIN_INDEX]) begin
            state_next = homing_pkg::ST_DONE;  // [R1]
          end
        end
        homing_pkg::ST_IDLE,
        homing_pkg::ST_DONE,
        homing_pkg::ST_FAULT: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  assign seg_load = seg_pick(plan_next, seg_idx_next);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= homing_pkg::ST_IDLE;
      case_reg    <= homing_pkg::CASE_CLEAR;
      plan_reg    <= '0;
      seg_idx_reg <= homing_pkg::SEG_IDX_RESET;
    end else begin
      state_reg   <= state_next;
      case_reg    <= case_next;
      plan_reg    <= plan_next;
      seg_idx_reg <= seg_idx_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      method_reg <= homing_pkg::METHOD_RESET;
    end else if (start && method_ok && state_next == homing_pkg::ST_MOVE &&
                 state_reg != homing_pkg::ST_MOVE) begin
      method_reg <= method_code;
    end
  end

  // ****************************************************************
  // Motion command outputs
  // ****************************************************************

  // Commands change in the same cycle as the state, so outputs track it exactly
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_en      <= 1'b0;
      dir_positive <= 1'b0;
      speed_high   <= 1'b0;
    end else if (state_next == homing_pkg::ST_MOVE ||
                 state_next == homing_pkg::ST_SEEK) begin
      move_en <= 1'b1;
      if (load_seg) begin
        dir_positive <= seg_load[homing_pkg::SEG_DIR_BIT];
        speed_high   <= seg_load[homing_pkg::SEG_FAST_BIT];
      end
    end else begin
      move_en    <= 1'b0;
      speed_high <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      home_found <= 1'b0;
      fault      <= 1'b0;
    end else begin
      busy       <= (state_next == homing_pkg::ST_MOVE) ||
                    (state_next == homing_pkg::ST_SEEK);
      home_found <= (state_next == homing_pkg::ST_DONE);
      fault      <= (state_next == homing_pkg::ST_FAULT);
    end
  end

endmodule : homing_switch_index_sequencer

//--- sim/homing_sequencer_sva.sv
// Purpose: Port-level checks for the switch-and-index homing sequencer
// Assumes: Pins held steady three cycles before a start is given
// Notes:   Bound to the sequencer from the bench top file
`timescale 1ns/1ps

module homing_sequencer_sva (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] method_code,
  input wire logic       start,
  input wire logic       halt,
  input wire logic       home_switch,
  input wire logic       pos_limit,
  input wire logic       neg_limit,
  input wire logic       move_en,
  input wire logic       dir_positive,
  input wire logic       speed_high,
  input wire logic       busy,
  input wire logic       home_found,
  input wire logic       fault
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = start && !halt && !busy;

  bad_method_a:
    assert property (take && (method_code < 8'h08 || method_code > 8'h0d)
      |=> fault && !move_en && !busy) else $error("bad method code not refused");
  // Switch level goes through two flops, so look back over the settled samples
  clear_pos_a:
    assert property (take && method_code inside {[8'h08:8'h0a]} && $past(rst_n, 3)
      && !$past(home_switch, 2) && !$past(home_switch, 3)
      |=> move_en && dir_positive && speed_high) else $error("clear start not fast positive");
  clear_neg_a:
    assert property (take && method_code inside {[8'h0b:8'h0d]} && $past(rst_n, 3)
      && !$past(home_switch, 2) && !$past(home_switch, 3)
      |=> move_en && !dir_positive && speed_high) else $error("clear start not fast negative");
  on_pos_a:
    assert property (take && method_code inside {[8'h09:8'h0c]} && $past(rst_n, 3)
      && $past(home_switch, 2) && $past(home_switch, 3)
      |=> move_en && dir_positive && !speed_high) else $error("on-switch start not slow positive");
  on_neg_a:
    assert property (take && (method_code == 8'h08 || method_code == 8'h0d) && $past(rst_n, 3)
      && $past(home_switch, 2) && $past(home_switch, 3)
      |=> move_en && !dir_positive && !speed_high) else $error("on-switch start not slow negative");
  home_stop_a:
    assert property ($rose(home_found) |-> !move_en && !busy && !speed_high)
      else $error("motion continues after home capture");
  slow_home_a:
    assert property ($rose(home_found) |-> $past(move_en) && !$past(speed_high))
      else $error("home captured outside a slow segment");
  step_cause_a:
    assert property (busy && $past(busy) && ($changed(dir_positive) || $changed(speed_high))
      |-> $past(home_switch, 2) != $past(home_switch, 6)
      || $past(pos_limit, 2) != $past(pos_limit, 6)
      || $past(neg_limit, 2) != $past(neg_limit, 6)) else $error("motion change without pin edge");
endmodule : homing_sequencer_sva

//--- sim/homing_axis_model.sv
// Purpose: Axis with home switch, travel limits and index track
// Assumes: Home active 100..200, limits at 400 and -30, index every 64
// Notes:   Fast moves 4 steps a cycle, slow moves 1; no inertia
`timescale 1ns/1ps

module homing_axis_model (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               move_en,
  input  wire logic               dir_positive,
  input  wire logic               speed_high,
  input  wire logic               preset_en,
  input  wire logic signed [15:0] preset_pos,
  input  wire logic        [1:0]  lim_kick,
  output logic                    home_switch,
  output logic                    pos_limit,
  output logic                    neg_limit,
  output logic                    index_pulse,
  output logic signed      [15:0] pos,
  output logic signed      [15:0] idx_pos
);
  logic idx_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 16'sh0;
    end else if (preset_en) begin
      pos <= preset_pos;
    end else if (move_en) begin
      pos <= pos + (dir_positive ? 16'sh1 : -16'sh1) * (speed_high ? 16'sh4 : 16'sh1);
    end
  end

  // Last index entry is the home mark, since the sequencer stops right after it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q   <= 1'b0;
      idx_pos <= 16'sh0;
    end else begin
      idx_q <= index_pulse;
      if (index_pulse && !idx_q) begin
        idx_pos <= pos;
      end
    end
  end

  assign home_switch = pos >= 16'sd100 && pos <= 16'sd200;
  assign pos_limit   = pos >= 16'sd400 || lim_kick[0];
  assign neg_limit   = pos <= -16'sd30 || lim_kick[1];
  assign index_pulse = pos >= 16'sd0 && pos[5:2] == 4'h0;
endmodule : homing_axis_model

//--- sim/tb_homing_switch_index_sequencer.sv
// Purpose: Runs every method and start case on a modelled axis
// Assumes: Sequencer answers a start at the next edge
// Notes:   Home position judged from where the index was entered
`timescale 1ns/1ps

module tb_homing_switch_index_sequencer;
  logic               sys_clk;
  logic               rst_n;
  logic        [7:0]  method_code;
  logic               start;
  logic               halt;
  logic               preset_en;
  logic signed [15:0] preset_pos;
  logic        [1:0]  lim_kick;
  logic               home_switch;
  logic               pos_limit;
  logic               neg_limit;
  logic               index_pulse;
  logic               move_en;
  logic               dir_positive;
  logic               speed_high;
  logic               busy;
  logic               home_found;
  logic               fault;
  logic signed [15:0] pos;
  logic signed [15:0] idx_pos;
  int                 error_cnt;
  int                 compares;
  // Negative final runs into the switch meet the index mark just below the upper switch edge
  int                 homes [6] = '{128, 195, 256, 256, 195, 128};

  homing_switch_index_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .method_code(method_code), .start(start), .halt(halt), .home_switch(home_switch),
    .pos_limit(pos_limit), .neg_limit(neg_limit), .index_pulse(index_pulse),
    .move_en(move_en), .dir_positive(dir_positive), .speed_high(speed_high),
    .busy(busy), .home_found(home_found), .fault(fault));

  homing_axis_model axis (.sys_clk(sys_clk), .rst_n(rst_n), .move_en(move_en),
    .dir_positive(dir_positive), .speed_high(speed_high), .preset_en(preset_en),
    .preset_pos(preset_pos), .lim_kick(lim_kick), .home_switch(home_switch),
    .pos_limit(pos_limit), .neg_limit(neg_limit), .index_pulse(index_pulse),
    .pos(pos), .idx_pos(idx_pos));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    while (busy === 1'b1 && n < limit) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("wrong value at %0t: sequencer stuck busy", $time);
      final_report();
    end
  endtask : wait_idle

  // Pins must settle three cycles before start samples the switch
  task automatic place(input logic signed [15:0] p);
    @(posedge sys_clk);
    preset_en  <= 1'b1;
    preset_pos <= p;
    @(posedge sys_clk);
    preset_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : place

  task automatic kick_off(input logic [7:0] code);
    method_code <= code;
    start       <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
  endtask : kick_off

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic homing_table;
    int         m;
    int         c;
    logic       on;
    logic       ed;
    logic [15:0] eh;
    for (m = 0; m < 6; m++) begin
      for (c = 0; c < 3; c++) begin
        on = (c == 1);
        ed = on ? !(m == 0 || m == 5) : (m < 3);
        eh = (m == 5 && c == 2) ? 16'd67 : 16'(homes[m]);
        if (on) place(16'sd150);
        else if ((m < 3) == (c == 0)) place(16'sd50);
        else place(m < 3 ? 16'sd300 : 16'sd250);
        kick_off(8'h08 + 8'(m));
        check(16'(move_en), 16'h1);
        check(16'(dir_positive), 16'(ed));
        check(16'(speed_high), 16'(!on));
        wait_idle(4000);
        check(16'(home_found), 16'h1);
        check(16'(fault), 16'h0);
        check(idx_pos, eh);
      end
    end
  endtask : homing_table

  task automatic fault_cases;
    logic [7:0] bad [4];
    int         i;
    bad = '{8'h00, 8'h07, 8'h0e, 8'hff};
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      kick_off(bad[i]);
      check(16'(fault), 16'h1);
      check(16'(move_en), 16'h0);
    end
    place(16'sd150);
    kick_off(8'h09);
    repeat (5) @(posedge sys_clk);
    kick_off(8'h07);
    check(16'(fault), 16'h0);
    check(16'(busy), 16'h1);
    lim_kick <= 2'h2;
    repeat (6) @(posedge sys_clk);
    lim_kick <= 2'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(16'(busy), 16'h1);
    lim_kick <= 2'h1;
    repeat (6) @(posedge sys_clk);
    #1;
    check(16'(fault), 16'h1);
    check(16'(move_en), 16'h0);
    lim_kick <= 2'h0;
  endtask : fault_cases

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n       = 1'b0;
    start       = 1'b0;
    halt        = 1'b0;
    method_code = 8'h00;
    preset_en   = 1'b0;
    preset_pos  = 16'sh0;
    lim_kick    = 2'h0;
    error_cnt   = 0;
    compares    = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    homing_table();
    fault_cases();
    final_report();
  end
endmodule : tb_homing_switch_index_sequencer

bind homing_switch_index_sequencer homing_sequencer_sva u_sva (.sys_clk(sys_clk),
  .rst_n(rst_n), .method_code(method_code), .start(start), .halt(halt),
  .home_switch(home_switch), .pos_limit(pos_limit), .neg_limit(neg_limit),
  .move_en(move_en), .dir_positive(dir_positive), .speed_high(speed_high),
  .busy(busy), .home_found(home_found), .fault(fault));
